// >>> logic/ivm_addr.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// vector fetch address former
// ---------------------------------------------------------------
module ivm_addr (
  input  wire logic [31:0] vector_base_register,
  input  wire logic [7:0]  vec,
  output logic      [31:0] fetch_addr
);
  import ivm_pkg::*;
  logic [9:0] ofs;
  // descending word offset as the vector number rises
  assign ofs        = TABLE_TOP_OFS - {vec, 2'b00};
  assign fetch_addr = vector_base_register + {22'h0, ofs};
endmodule // ivm_addr

// >>> logic/ivm_pkg.sv
// Functional notes
// - vectors 80-255 only via software trap
// - vectors 64,65 reserved, no source, no level
// - vector 63 from delayed bit, last level
// - vector 46 shared: timer 3, oscillator wait
// - vector 57 shared: capture 1, serial tx
// - arbitrate by level, then vector number
package ivm_pkg;
  // ---------------------------------------------------------------
  // vector map constants
  // ---------------------------------------------------------------
  localparam int unsigned NUM_SRC        = 48;  // level registers 0..47
  localparam logic [7:0]  FIRST_HW_VEC   = 8'h10;
  localparam logic [7:0]  DELAY_VEC      = 8'h3f;
  localparam logic [7:0]  SHARED_TMR_VEC = 8'h2e;
  localparam logic [7:0]  SHARED_CAP_VEC = 8'h39;
  localparam logic [7:0]  RTOS_VEC_LO    = 8'h40;
  localparam logic [7:0]  RTOS_VEC_HI    = 8'h41;
  localparam logic [7:0]  TRAP_VEC_LO    = 8'h50;
  localparam logic [9:0]  TABLE_TOP_OFS  = 10'h3fc;
  localparam logic [4:0]  LEVEL_NONE     = 5'h1f; // lowest level, masks the source
  localparam logic [4:0]  LEVEL_RST      = 5'h1f;
  localparam logic [31:0] VBR_RST        = 32'h000ffc00;
  localparam int unsigned SHARED_TMR_IDX = 30;
  localparam int unsigned SHARED_CAP_IDX = 41;
  localparam int unsigned DELAY_IDX      = 47;

  typedef enum logic [1:0] {
    IVM_IDLE  = 2'b00,
    IVM_FETCH = 2'b01
  } ivm_state_t;
endpackage

// >>> logic/ivm_top.sv
`timescale 1ns/1ps
module ivm_top (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic [ivm_pkg::NUM_SRC-1:0]  src_req,
  input  wire logic                         timer3_req,
  input  wire logic                         osc_wait_req,
  input  wire logic                         capture1_req,
  input  wire logic                         serial4_tx_req,
  input  wire logic                         delay_set,
  input  wire logic                         delay_clear,
  input  wire logic [ivm_pkg::NUM_SRC*5-1:0] source_level_register,
  input  wire logic [31:0]                  vector_base_register,
  input  wire logic                         trap_valid,
  input  wire logic [7:0]                   trap_vec,
  output logic                              irq_valid,
  output logic      [4:0]                   irq_level,
  output logic      [7:0]                   irq_vec,
  output logic      [31:0]                  irq_fetch_addr,
  output logic                              trap_fetch_valid,
  output logic      [31:0]                  trap_fetch_addr,
  output logic                              delay_pending
);
  import ivm_pkg::*;

  // ---------------------------------------------------------------
  // behaviour at the cpu side
  // ---------------------------------------------------------------
  // every input but rst is taken at each rising edge of sys_clk and the
  // registered outputs show the result one cycle later; delay_set and
  // delay_clear reach the irq outputs one cycle after delay_pending.
  // irq_valid, irq_level, irq_vec and irq_fetch_addr follow the
  // pending requests on every cycle; they are levels, not pulses.
  // a source whose level field holds 31 never wins, so software can
  // mask a source by writing 31 into its level field.
  // on equal levels the lower vector number wins.
  // trap_fetch_valid is high for one cycle per cycle of trap_valid
  // whose vector is 80 or above; vectors below 80 are refused so
  // that the reserved entries 64..79 are never fetched by a trap.
  // while no request wins the address outputs rest at the fixed VBR_RST,
  // which is the table bottom only while vector_base_register holds it.
  // src_req bit 47 is not used: vector 63 comes from the delayed
  // bit, which software sets and clears through delay_set and
  // delay_clear; when both arrive in one cycle the set wins so a
  // task switch request is never lost.
  // vector 46 and vector 57 each merge two extra request lines into
  // one request that shares one level field.

  // ---------------------------------------------------------------
  // request gathering
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] req;
  logic               next_delay_pending;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_req
      if (g == SHARED_TMR_IDX) begin : g_tmr
        assign req[g] = src_req[g] | timer3_req | osc_wait_req;
      end else if (g == SHARED_CAP_IDX) begin : g_cap
        assign req[g] = src_req[g] | capture1_req | serial4_tx_req;
      end else if (g == DELAY_IDX) begin : g_dly
        assign req[g] = delay_pending;
      end else begin : g_plain
        assign req[g] = src_req[g];
      end
    end
  endgenerate

  // delayed-interrupt bit: set wins over clear
  always_comb begin
    next_delay_pending = delay_pending;
    if (delay_clear) begin
      next_delay_pending = 1'b0;
    end
    if (delay_set) begin
      next_delay_pending = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  function automatic logic [4:0] level_of(input logic [NUM_SRC*5-1:0] lv, input int i);
    level_of = lv[i*5 +: 5];
  endfunction

  logic [4:0] win_level;
  logic [7:0] win_vec;
  logic       win_any;

  // lower level value wins; scanning upward keeps the lower number on ties
  always_comb begin
    win_level = LEVEL_NONE;
    win_vec   = FIRST_HW_VEC;
    win_any   = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req[i] && level_of(source_level_register, i) < win_level) begin
        win_level = level_of(source_level_register, i);
        win_vec   = FIRST_HW_VEC + 8'(i);
        win_any   = 1'b1;
      end
    end
  end

  logic [31:0] win_addr;
  logic [31:0] trap_addr;

  ivm_addr u_irq_addr (
    .vector_base_register (vector_base_register),
    .vec                  (win_vec),
    .fetch_addr           (win_addr)
  );

  ivm_addr u_trap_addr (
    .vector_base_register (vector_base_register),
    .vec                  (trap_vec),
    .fetch_addr           (trap_addr)
  );

  // only trap vectors 80..255 are taken from the trap port; reserved ones refused
  function automatic logic trap_ok(input logic [7:0] v);
    trap_ok = (v >= TRAP_VEC_LO);
  endfunction

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  logic        next_irq_valid;
  logic [4:0]  next_irq_level;
  logic [7:0]  next_irq_vec;
  logic [31:0] next_irq_fetch_addr;
  logic        next_trap_fetch_valid;
  logic [31:0] next_trap_fetch_addr;

  always_comb begin
    next_irq_valid        = win_any;
    next_irq_level        = win_any ? win_level : LEVEL_NONE;
    next_irq_vec          = win_any ? win_vec : 8'h00;
    next_irq_fetch_addr   = win_any ? win_addr : VBR_RST;
    next_trap_fetch_valid = trap_valid && trap_ok(trap_vec);
    next_trap_fetch_addr  = next_trap_fetch_valid ? trap_addr : VBR_RST;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_valid        <= 1'b0;
      irq_level        <= LEVEL_RST;
      irq_vec          <= 8'h00;
      irq_fetch_addr   <= VBR_RST;
      trap_fetch_valid <= 1'b0;
      trap_fetch_addr  <= VBR_RST;
      delay_pending    <= 1'b0;
    end else begin
      irq_valid        <= next_irq_valid;
      irq_level        <= next_irq_level;
      irq_vec          <= next_irq_vec;
      irq_fetch_addr   <= next_irq_fetch_addr;
      trap_fetch_valid <= next_trap_fetch_valid;
      trap_fetch_addr  <= next_trap_fetch_addr;
      delay_pending    <= next_delay_pending;
    end
  end
endmodule // ivm_top

// >>> tb/ivm_cpu.sv
`timescale 1ns/1ps
// cpu side: keeps the last vector number offered to it
module ivm_cpu (
  input  wire logic       sys_clk, rst, irq_valid,
  input  wire logic [7:0] irq_vec,
  output logic      [7:0] last_vec
);
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) last_vec <= 8'h00;
    else if (irq_valid) last_vec <= irq_vec;
endmodule // ivm_cpu

// >>> tb/ivm_sva.sv
`timescale 1ns/1ps
module ivm_sva (
  input wire logic         sys_clk, rst, trap_valid, trap_fetch_valid, irq_valid,
  input wire logic         timer3_req, osc_wait_req, capture1_req, serial4_tx_req,
  input wire logic [239:0] source_level_register,
  input wire logic [31:0]  vector_base_register, irq_fetch_addr, trap_fetch_addr,
  input wire logic [7:0]   trap_vec, irq_vec,
  input wire logic [4:0]   irq_level
);
  logic [239:0] slr_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // level registers as seen one edge earlier
  always_ff @(posedge sys_clk) slr_q <= source_level_register;
  a_irq_addr: assert property (irq_valid |->
    irq_fetch_addr == $past(vector_base_register) + 32'h3fc - {irq_vec, 2'b00})
    else $error("irq fetch address wrong");
  a_trap_addr: assert property (trap_fetch_valid |->
    trap_fetch_addr == $past(vector_base_register) + 32'h3fc - {$past(trap_vec), 2'b00})
    else $error("trap fetch address wrong");
  a_trap_take: assert property (trap_valid && trap_vec >= 8'h50 |=> trap_fetch_valid)
    else $error("trap not accepted");
  a_trap_refuse: assert property (trap_valid && trap_vec < 8'h50 |=> !trap_fetch_valid)
    else $error("low trap vector accepted");
  a_no_rtos: assert property (irq_valid |-> irq_vec inside {[8'h10:8'h3f]})
    else $error("irq vector outside hardware range");
  a_timer_share: assert property ((timer3_req || osc_wait_req) &&
    source_level_register[154:150] == 5'h00 |=> irq_valid && irq_level == 5'h00)
    else $error("shared timer request lost");
  a_capture_share: assert property ((capture1_req || serial4_tx_req) &&
    source_level_register[209:205] == 5'h00 |=> irq_valid && irq_level == 5'h00)
    else $error("shared capture request lost");
  a_win_level: assert property (irq_valid |-> irq_level != 5'h1f &&
    irq_level == slr_q[int'(irq_vec) * 5 - 80 +: 5])
    else $error("winner level mismatch");
  c_trap: cover property (trap_fetch_valid);
  c_delay: cover property (irq_valid && irq_vec == 8'h3f);
  c_shared: cover property (irq_valid && irq_vec == 8'h39);
endmodule // ivm_sva
bind ivm_top ivm_sva ivm_sva_inst (.*);

// >>> tb/test_interrupt_vector_map.sv
`timescale 1ns/1ps
module test_interrupt_vector_map;
  logic sys_clk = 0, rst = 1, timer3_req = 0, osc_wait_req = 0, capture1_req = 0, dp = 0;
  logic serial4_tx_req = 0, delay_set = 0, delay_clear = 0, trap_valid = 0, tf;
  logic irq_valid, trap_fetch_valid, delay_pending;
  logic [47:0]  src_req = '0;
  logic [255:0] slr = '1;
  wire  [239:0] source_level_register = slr[239:0];
  logic [31:0]  vector_base_register = 0, irq_fetch_addr, trap_fetch_addr, ea;
  logic [7:0]   trap_vec = 0, irq_vec, last_vec, ev, lv = 0;
  logic [4:0]   irq_level, el;
  integer seed = 32'ha04d;
  int error_cnt = 0, checks = 0;
  ivm_top ivm_top_inst (.*);
  ivm_cpu ivm_cpu_inst (.*);
  task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // expected winner: lowest level value, ties to the lowest vector
  function automatic void pick;
    logic r;
    el = 5'h1f;
    ev = 0;
    for (int i = 47; i >= 0; i--) begin
      r = i == 47 ? dp : src_req[i] | (i == 30 & (timer3_req | osc_wait_req))
        | (i == 41 & (capture1_req | serial4_tx_req));
      if (r && slr[5*i+:5] != 5'h1f && slr[5*i+:5] <= el) begin
        el = slr[5*i+:5];
        ev = 8'(i + 16);
      end
    end
    ea = el == 5'h1f ? 32'h000ffc00 : vector_base_register + 32'h3fc - {ev, 2'b00};
    tf = trap_valid & (trap_vec >= 8'h50);
  endfunction
  initial forever #5 sys_clk = ~sys_clk;
  // watchdog
  initial begin
    #50000;
    error_cnt++;
    final_report;
  end
  // random traffic with hand-placed corners, inputs held three edges
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 0;
    for (int n = 0; n < 400; n++) begin
      if (n == 200) begin
        // mid-run reset: every output back to its rest value
        rst = 1;
        @(negedge sys_clk);
        chk(irq_valid, 0);
        chk(irq_level, 5'h1f);
        chk(irq_vec, 0);
        chk(irq_fetch_addr, 32'h000ffc00);
        chk(trap_fetch_valid, 0);
        chk(trap_fetch_addr, 32'h000ffc00);
        chk(delay_pending, 0);
        chk(last_vec, 0);
        rst = 0;
        dp = 0;
        lv = 0;
      end
      src_req = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
      for (int k = 0; k < 8; k++) slr[32*k+:32] = $random(seed);
      {trap_valid, delay_set, delay_clear, timer3_req, osc_wait_req, capture1_req,
        serial4_tx_req} = 7'($random(seed));
      vector_base_register = $random(seed);
      trap_vec = 8'($random(seed));
      case (n)
        0: begin slr = {48{5'h04}}; src_req = '1; end
        1: begin trap_valid = 1; trap_vec = 8'h4f; end
        2: begin trap_valid = 1; trap_vec = 8'h50; end
        3: begin trap_valid = 1; trap_vec = 8'hff; end
        4: begin src_req = 0; slr[239:235] = 5'h02; delay_set = 1; end
        default: ;
      endcase
      dp = delay_set | (dp & ~delay_clear);
      pick();
      if (el != 5'h1f) lv = ev;
      // third edge lets the cpu model take the settled winner
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(irq_valid, el != 5'h1f);
      chk(irq_vec, ev);
      chk(irq_level, el);
      chk(irq_fetch_addr, ea);
      chk(trap_fetch_valid, tf);
      chk(trap_fetch_addr, tf ? vector_base_register + 32'h3fc - {trap_vec, 2'b00}
        : 32'h000ffc00);
      chk(delay_pending, dp);
      chk(last_vec, lv);
    end
    final_report;
  end
endmodule // test_interrupt_vector_map
